// >>> rtl/ddss_pkg.sv
// shared constants of the driver diagnostic status and serial port block
package ddss_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 20;
  localparam int FILT_NS  = 30;
  localparam int FILT_RAW = (FILT_NS * CLK_MHZ) / 1000;
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam int FCNT_W   = 4;
  // ----------------------------------------------------------------
  // serial frame and status layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 20;
  localparam int STAT_W     = 8;
  localparam int UPPER_W    = FRAME_BITS - STAT_W;
  localparam int BCNT_W     = 5;
  localparam int BIT_STST   = 7;
  localparam int BIT_OL_B   = 6;
  localparam int BIT_OL_A   = 5;
  localparam int BIT_GS_B   = 4;
  localparam int BIT_GS_A   = 3;
  localparam int BIT_OVERTEMP_PREWARN   = 2;
  localparam int BIT_OT     = 1;
  localparam int BIT_STALL  = 0;
  // ----------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------
  localparam int CUR_W      = 8;
  localparam int OL_SHIFT   = 4;
  localparam int SCNT_W     = 2;
  localparam logic [SCNT_W-1:0] SHORT_LIMIT = 2'h3;
endpackage : ddss_pkg

// >>> rtl/ddss_sync_filt.sv
// two-stage synchroniser with glitch filter for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ddss_sync_filt #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] filt_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_i) begin
    meta_r <= pin_i;
    sync_r <= meta_r;
  end

  // ----------------------------------------------------------------
  // per bit: new level taken only after it stands long enough
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [ddss_pkg::FCNT_W-1:0] cnt_r;
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        cnt_r     <= '0;
        filt_o[i] <= rst_val_i[i];
      end else if (sync_r[i] == filt_o[i]) begin
        cnt_r <= '0;
      end else if (cnt_r == ddss_pkg::FCNT_W'(ddss_pkg::FILT_CYC - 1)) begin
        cnt_r     <= '0;
        filt_o[i] <= sync_r[i];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : ddss_sync_filt
`default_nettype wire

// >>> rtl/ddss_short_guard.sv
// short counter and latched shutdown for one bridge
`timescale 1ns/100ps
`default_nettype none
module ddss_short_guard (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic disabled_i,
  input  wire logic short_i,
  input  wire logic pol_chg_i,
  output logic      shut_o,
  output logic      abort_o
);
  logic [ddss_pkg::SCNT_W-1:0] cnt_r;
  logic [ddss_pkg::SCNT_W-1:0] cnt_nxt;
  wire inc = short_i && cnt_r != ddss_pkg::SHORT_LIMIT;
  wire dec = pol_chg_i && cnt_r != '0;

  assign cnt_nxt = cnt_r + ddss_pkg::SCNT_W'(inc) - ddss_pkg::SCNT_W'(dec);

  always_ff @(posedge clk_i) begin
    if (reset_i || disabled_i) begin
      cnt_r   <= '0;
      shut_o  <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      cnt_r   <= shut_o ? cnt_r : cnt_nxt;
      shut_o  <= shut_o || cnt_nxt == ddss_pkg::SHORT_LIMIT;
      abort_o <= short_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_short_abort: assert property (short_i && !disabled_i |=> abort_o)
    else $error("chopper cycle not ended on short");
  a_cnt_step: assert property (!disabled_i && !shut_o && short_i && !pol_chg_i
      && cnt_r == 2'h1 |=> cnt_r == 2'h2 || disabled_i)
    else $error("short counter did not count up");
  a_shut_hold: assert property (shut_o && !disabled_i |=> shut_o)
    else $error("shutdown released without disable");
  a_shut_clear: assert property (disabled_i |=> !shut_o && cnt_r == '0)
    else $error("disable did not clear short state");
endmodule : ddss_short_guard
`default_nettype wire

// >>> rtl/ddss_top.sv
// diagnostic status bits and system-clock serial port of the driver
// Notes on behaviour
// - coil without chopper event sets open load
// - only current above max/16 clears open load
// - short ends running chopper cycle
// - each short counts the short counter up
// - each polarity change counts it down
// - count of three shuts driver off, latched
// - disable then enable clears short shutdown
// - ground short flags per high side bridge
// - overtemperature shutdown reported at bit one
// - stall flag at bit zero and pin
// - serial pins sampled by system clock
// - serial and enable inputs glitch filtered
// - input data captured on rising edge
// - output data changes after falling edge
`timescale 1ns/100ps
`default_nettype none
module ddss_top (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            sck_i,
  input  wire logic                            sdi_i,
  input  wire logic                            chip_select_n_i,
  input  wire logic                            driver_enable_n_i,
  input  wire logic                            pol_a_i,
  input  wire logic                            pol_b_i,
  input  wire logic                            chop_evt_a_i,
  input  wire logic                            chop_evt_b_i,
  input  wire logic [ddss_pkg::CUR_W-1:0]      cur_a_i,
  input  wire logic [ddss_pkg::CUR_W-1:0]      cur_b_i,
  input  wire logic [ddss_pkg::CUR_W-1:0]      cur_max_i,
  input  wire logic                            short_a_i,
  input  wire logic                            short_b_i,
  input  wire logic                            overtemp_shutdown_i,
  input  wire logic                            overtemp_prewarn_i,
  input  wire logic                            load_stall_i,
  input  wire logic                            standstill_i,
  input  wire logic [ddss_pkg::UPPER_W-1:0]    read_upper_i,
  output logic                                 sdo_o,
  output logic                                 sdo_oe_o,
  output logic                                 load_stall_flag_o,
  output logic                                 driver_on_o,
  output logic                                 chop_abort_a_o,
  output logic                                 chop_abort_b_o,
  output logic [ddss_pkg::STAT_W-1:0]          status_o,
  output logic [ddss_pkg::FRAME_BITS-1:0]      wr_data_o,
  output logic                                 wr_valid_o
);
  // ----------------------------------------------------------------
  // pin synchronisation and filtering
  // ----------------------------------------------------------------
  logic [3:0] pins_f;
  logic       sck_f;
  logic       sdi_f;
  logic       csn_f;
  logic       enn_f;

  ddss_sync_filt #(.W(4)) u_filt (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .pin_i     ({driver_enable_n_i, chip_select_n_i, sdi_i, sck_i}),
    .rst_val_i (4'hc),
    .filt_o    (pins_f)
  );

  assign sck_f = pins_f[0];
  assign sdi_f = pins_f[1];
  assign csn_f = pins_f[2];
  assign enn_f = pins_f[3];

  // ----------------------------------------------------------------
  // open load detection
  // ----------------------------------------------------------------
  function automatic logic ol_clear(input logic [ddss_pkg::CUR_W-1:0] cur,
                                    input logic [ddss_pkg::CUR_W-1:0] cmax);
    ol_clear = cur > (cmax >> ddss_pkg::OL_SHIFT);
  endfunction : ol_clear

  function automatic logic ol_next(input logic ol, input logic seen,
                                   input logic chg, input logic clr);
    ol_next = (chg && !seen) || (ol && !clr);
  endfunction : ol_next

  logic pol_a_r;
  logic pol_b_r;
  logic seen_a_r;
  logic seen_b_r;
  logic ol_a_r;
  logic ol_b_r;

  wire chg_a    = pol_a_i != pol_a_r;
  wire chg_b    = pol_b_i != pol_b_r;
  wire seen_a   = seen_a_r || chop_evt_a_i;
  wire seen_b   = seen_b_r || chop_evt_b_i;
  wire clr_a    = ol_clear(cur_a_i, cur_max_i);
  wire clr_b    = ol_clear(cur_b_i, cur_max_i);
  wire ol_a_nxt = ol_next(ol_a_r, seen_a, chg_a, clr_a);
  wire ol_b_nxt = ol_next(ol_b_r, seen_b, chg_b, clr_b);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pol_a_r  <= 1'b0;
      pol_b_r  <= 1'b0;
      seen_a_r <= 1'b0;
      seen_b_r <= 1'b0;
      ol_a_r   <= 1'b0;
      ol_b_r   <= 1'b0;
    end else begin
      pol_a_r  <= pol_a_i;
      pol_b_r  <= pol_b_i;
      seen_a_r <= seen_a && !chg_a;
      seen_b_r <= seen_b && !chg_b;
      ol_a_r   <= ol_a_nxt;
      ol_b_r   <= ol_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // short protection per bridge
  // ----------------------------------------------------------------
  logic shut_a;
  logic shut_b;

  ddss_short_guard u_guard_a (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .disabled_i (enn_f),
    .short_i    (short_a_i),
    .pol_chg_i  (chg_a),
    .shut_o     (shut_a),
    .abort_o    (chop_abort_a_o)
  );

  ddss_short_guard u_guard_b (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .disabled_i (enn_f),
    .short_i    (short_b_i),
    .pol_chg_i  (chg_b),
    .shut_o     (shut_b),
    .abort_o    (chop_abort_b_o)
  );

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  logic [ddss_pkg::STAT_W-1:0] stat_w;

  always_comb begin
    stat_w                      = '0;
    stat_w[ddss_pkg::BIT_STST]  = standstill_i;
    stat_w[ddss_pkg::BIT_OL_B]  = ol_b_r;
    stat_w[ddss_pkg::BIT_OL_A]  = ol_a_r;
    stat_w[ddss_pkg::BIT_GS_B]  = shut_b;
    stat_w[ddss_pkg::BIT_GS_A]  = shut_a;
    stat_w[ddss_pkg::BIT_OVERTEMP_PREWARN]  = overtemp_prewarn_i;
    stat_w[ddss_pkg::BIT_OT]    = overtemp_shutdown_i;
    stat_w[ddss_pkg::BIT_STALL] = load_stall_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_o          <= '0;
      load_stall_flag_o <= 1'b0;
      driver_on_o       <= 1'b0;
    end else begin
      status_o          <= stat_w;
      load_stall_flag_o <= load_stall_i;
      driver_on_o       <= !enn_f && !shut_a && !shut_b && !overtemp_shutdown_i;
    end
  end

  // ----------------------------------------------------------------
  // serial port on system clock
  // ----------------------------------------------------------------
  logic                             sck_q_r;
  logic                             csn_q_r;
  logic [ddss_pkg::FRAME_BITS-1:0]  sh_in_r;
  logic [ddss_pkg::FRAME_BITS-1:0]  sh_out_r;
  logic [ddss_pkg::BCNT_W-1:0]      bcnt_r;
  logic [ddss_pkg::BCNT_W-1:0]      bcnt_base;
  logic [ddss_pkg::BCNT_W-1:0]      bcnt_nxt;

  wire sck_rise = sck_f && !sck_q_r && !csn_f;
  wire sck_fall = !sck_f && sck_q_r && !csn_f;
  wire csn_fall = !csn_f && csn_q_r;
  wire csn_rise = csn_f && !csn_q_r;
  wire full     = bcnt_r == ddss_pkg::BCNT_W'(ddss_pkg::FRAME_BITS);
  wire [ddss_pkg::FRAME_BITS-1:0] resp = {read_upper_i, stat_w};

  // select fall and first rising edge in one cycle restart the count at one
  assign bcnt_base = csn_fall ? '0 : bcnt_r;
  assign bcnt_nxt  = (sck_rise && bcnt_base != ddss_pkg::BCNT_W'(ddss_pkg::FRAME_BITS))
                     ? bcnt_base + 1'b1 : bcnt_base;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sck_q_r    <= 1'b0;
      csn_q_r    <= 1'b1;
      sh_in_r    <= '0;
      sh_out_r   <= '0;
      bcnt_r     <= '0;
      sdo_o      <= 1'b0;
      sdo_oe_o   <= 1'b0;
      wr_data_o  <= '0;
      wr_valid_o <= 1'b0;
    end else begin
      sck_q_r    <= sck_f;
      csn_q_r    <= csn_f;
      sdo_oe_o   <= !csn_f;
      wr_valid_o <= csn_rise && full;
      if (csn_rise && full) begin
        wr_data_o <= sh_in_r;
      end
      bcnt_r     <= bcnt_nxt;
      if (csn_fall) begin
        sdo_o    <= resp[ddss_pkg::FRAME_BITS-1];
        sh_out_r <= {resp[ddss_pkg::FRAME_BITS-2:0], 1'b0};
      end else if (sck_fall) begin
        sdo_o    <= sh_out_r[ddss_pkg::FRAME_BITS-1];
        sh_out_r <= {sh_out_r[ddss_pkg::FRAME_BITS-2:0], 1'b0};
      end
      if (sck_rise) begin
        sh_in_r <= {sh_in_r[ddss_pkg::FRAME_BITS-2:0], sdi_f};
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions: open load
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_ol_set_nochop: assert property (chg_a && !seen_a |=> ol_a_r)
    else $error("open load A not set after silent period");
  a_ol_keep_low: assert property (ol_b_r && !clr_b |=> ol_b_r)
    else $error("open load B cleared without enough current");
  a_ol_clear_cur: assert property (ol_a_r && clr_a && !chg_a |=> !ol_a_r)
    else $error("open load A not cleared by current");
  a_ol_a_keep: assert property (ol_a_r && !clr_a |=> ol_a_r)
    else $error("open load A cleared without enough current");
  a_ol_b_set: assert property (chg_b && !seen_b |=> ol_b_r)
    else $error("open load B not set after silent period");
  a_ol_no_false: assert property (!ol_a_r && chg_a && seen_a |=> !ol_a_r)
    else $error("open load A set despite chopper event");
  a_ol_b_clear: assert property (ol_b_r && clr_b && !chg_b |=> !ol_b_r)
    else $error("open load B not cleared by current");
  a_ol_stat_bits: assert property (status_o[ddss_pkg::BIT_OL_A] == $past(ol_a_r)
      && status_o[ddss_pkg::BIT_OL_B] == $past(ol_b_r))
    else $error("open load status bit wrong");

  // ----------------------------------------------------------------
  // assertions: short protection and status
  // ----------------------------------------------------------------
  a_gnd_short_bit: assert property (status_o[ddss_pkg::BIT_GS_A] == $past(shut_a)
      && status_o[ddss_pkg::BIT_GS_B] == $past(shut_b))
    else $error("ground short status bit wrong");
  a_short_drv_off: assert property (shut_a || shut_b |=> !driver_on_o)
    else $error("driver on while short latched");
  a_abort_b: assert property (short_b_i && !enn_f |=> chop_abort_b_o)
    else $error("chopper cycle B not ended on short");
  a_enable_off: assert property (enn_f |=> !driver_on_o)
    else $error("driver on while disabled");
  a_ot_status_bit: assert property (overtemp_shutdown_i |=>
      status_o[ddss_pkg::BIT_OT] && !driver_on_o)
    else $error("overtemperature not reported");
  a_stall_pin_bit: assert property (load_stall_flag_o == status_o[ddss_pkg::BIT_STALL])
    else $error("stall pin and status differ");

  // ----------------------------------------------------------------
  // assertions: serial port
  // ----------------------------------------------------------------
  a_sdo_on_fall: assert property ($changed(sdo_o) |-> $past(sck_fall || csn_fall))
    else $error("serial output moved without falling edge");
  a_sdi_on_rise: assert property (sck_rise && !csn_fall |=>
      sh_in_r[0] == $past(sdi_f))
    else $error("serial input not captured on rising edge");
  a_frame_valid: assert property (csn_rise && full |=> wr_valid_o ##1 !wr_valid_o)
    else $error("frame end not flagged for one cycle");
  a_short_frame: assert property (csn_rise && !full |=> !wr_valid_o)
    else $error("frame of wrong length accepted");
  a_frame_data: assert property (csn_rise && full |=> wr_data_o == $past(sh_in_r))
    else $error("received frame not handed over");
  a_sck_deselect: assert property (csn_f |=> $stable(sh_in_r))
    else $error("serial clock taken while deselected");
  a_first_bit: assert property (csn_fall |=>
      sdo_o == $past(resp[ddss_pkg::FRAME_BITS-1]))
    else $error("first reply bit not on select fall");
  a_oe_selected: assert property (!csn_f |=> sdo_oe_o)
    else $error("serial output not enabled while selected");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------

  c_full_frame: cover property (csn_rise && full);
  c_open_load:  cover property (!ol_a_r ##1 ol_a_r);
  c_short_shut: cover property (!shut_a ##1 shut_a);
  c_reenable:   cover property (shut_b ##1 !shut_b);
  c_short_frame: cover property (csn_rise && !full);
endmodule : ddss_top
`default_nettype wire

// >>> sim/ddss_spi_master.sv
// serial master model that stands across the serial port
`timescale 1ns/100ps
`default_nettype none
module ddss_spi_master (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output var logic  sck_o,
  output var logic  sdi_o,
  output var logic  csn_o
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // clock stands low outside frames
  initial begin
    sck_o = 1'h0;
    sdi_o = 1'h0;
    csn_o = 1'h1;
  end

  // ----------------------------------------------------------------
  // one frame, msb first, n bits
  // ----------------------------------------------------------------
  // six system clocks per half period, well under half rate
  task automatic xfer(input logic [19:0] tx, input int n, output logic [19:0] rx);
    int lo;
    lo = 20 - n;
    rx = 20'h0_0000;
    @(posedge clk_i);
    csn_o <= 1'h0;
    sdi_o <= tx[19];
    repeat (6) @(posedge clk_i);
    for (int i = 19; i >= lo; i--) begin
      // reply bit sampled at the rising edge
      rx[i] = sdo_i;
      sck_o <= 1'h1;
      repeat (6) @(posedge clk_i);
      sck_o <= 1'h0;
      // data moves only after the falling edge
      sdi_o <= (i > lo) ? tx[i-1] : ~tx[i];
      repeat (6) @(posedge clk_i);
    end
    csn_o <= 1'h1;
  endtask : xfer
endmodule : ddss_spi_master
`default_nettype wire

// >>> sim/driver_diag_status_spi_test.sv
// self-checking bench of the diagnostic status and serial port block
`timescale 1ns/100ps
`default_nettype none
module driver_diag_status_spi_test;
  logic        clk, reset, sck, sdi, chip_select_n, driver_enable_n, ot, pw, stall, stst, sdo, sdo_oe;
  logic        wr_valid, stall_pin, drv_on, abort_a, abort_b, got;
  logic [1:0]  pol, chop, shrt;
  logic [7:0]  cur_a, cur_b, cur_max, status;
  logic [11:0] upper;
  logic [19:0] wr_data, rx, tx;
  int          n_mismatch, n_compared, seed;
  int          ol_m[2];
  int          cnt_m[2];
  // deselected reply line floats: the model sees the inverse of the last bit
  wire logic   sdo_line = sdo_oe ? sdo : ~sdo;

  ddss_top i_dut (
    .clk_i(clk), .reset_i(reset), .sck_i(sck), .sdi_i(sdi), .chip_select_n_i(chip_select_n),
    .driver_enable_n_i(driver_enable_n), .pol_a_i(pol[0]), .pol_b_i(pol[1]),
    .chop_evt_a_i(chop[0]), .chop_evt_b_i(chop[1]), .cur_a_i(cur_a), .cur_b_i(cur_b),
    .cur_max_i(cur_max), .short_a_i(shrt[0]), .short_b_i(shrt[1]),
    .overtemp_shutdown_i(ot), .overtemp_prewarn_i(pw), .load_stall_i(stall),
    .standstill_i(stst), .read_upper_i(upper), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .load_stall_flag_o(stall_pin), .driver_on_o(drv_on), .chop_abort_a_o(abort_a),
    .chop_abort_b_o(abort_b), .status_o(status), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid)
  );
  ddss_spi_master i_master (.clk_i(clk), .sdo_i(sdo_line), .sck_o(sck), .sdi_o(sdi), .csn_o(chip_select_n));

  // ----------------------------------------------------------------
  // clock, checking and closing
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // model of the status byte
  function automatic logic [7:0] exp_stat();
    return {stst, ol_m[1] != 0, ol_m[0] != 0, cnt_m[1] >= 3, cnt_m[0] >= 3, pw, ot, stall};
  endfunction : exp_stat

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("unexpected run length: limit reached");
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h7ed1;
    n_mismatch = 0;
    n_compared = 0;
    reset = 1'h1;
    driver_enable_n = 1'h0;
    {ot, pw, stall, stst} = 4'h0;
    pol = 2'h0;
    chop = 2'h0;
    shrt = 2'h0;
    cur_a = 8'h00;
    cur_b = 8'h00;
    cur_max = 8'($random(seed)) | 8'h10;
    upper = 12'h000;
    ol_m = '{0, 0};
    cnt_m = '{0, 0};
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    wait_clk(8);
    chk("status", status, exp_stat());
    chk("driver on", drv_on, 1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {ot, pw, stall, stst} <= 4'($random(seed));
      wait_clk(3);
      chk("status", status, exp_stat());
      chk("stall pin", stall_pin, stall);
      chk("driver on", drv_on, !ot);
    end
    @(posedge clk);
    {ot, pw, stall, stst} <= 4'h0;
    $display("test level flags done");
    // coil a changes with no chopper event, coil b with one
    for (int c = 0; c < 2; c++) begin
      if (c == 1) begin
        @(posedge clk);
        chop[1] <= 1'h1;
        @(posedge clk);
        chop[1] <= 1'h0;
      end
      @(posedge clk);
      pol[c] <= ~pol[c];
      ol_m[c] = (c == 0);
      wait_clk(4);
      chk("status", status, exp_stat());
    end
    @(posedge clk);
    cur_a <= cur_max >> 4;
    wait_clk(4);
    chk("status", status, exp_stat());
    @(posedge clk);
    cur_a <= (cur_max >> 4) + 8'h01;
    ol_m[0] = 0;
    wait_clk(4);
    chk("status", status, exp_stat());
    @(posedge clk);
    cur_a <= 8'h00;
    $display("test open load done");
    // short, short, polarity change, short, short per bridge
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 5; k++) begin
        @(posedge clk);
        if (k == 2)
          pol[c] <= ~pol[c];
        else
          shrt[c] <= 1'h1;
        @(posedge clk);
        shrt[c] <= 1'h0;
        #1;
        if (k == 2) begin
          cnt_m[c]--;
          ol_m[c] = 1;
        end else begin
          cnt_m[c]++;
          chk("chopper abort", c ? abort_b : abort_a, 1);
        end
        wait_clk(3);
        chk("status", status, exp_stat());
        chk("driver on", drv_on, cnt_m[c] < 3);
      end
      @(posedge clk);
      pol[c] <= ~pol[c];
      wait_clk(4);
      chk("status", status, exp_stat());
      @(posedge clk);
      driver_enable_n <= 1'h1;
      wait_clk(6);
      chk("driver on", drv_on, 0);
      @(posedge clk);
      driver_enable_n <= 1'h0;
      cnt_m[c] = 0;
      wait_clk(6);
      chk("status", status, exp_stat());
      chk("driver on", drv_on, 1);
    end
    // coil b current: random draw, then just above the clear threshold
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      tx[7:0] = (s == 0) ? 8'($random(seed)) : (cur_max >> 4) + 8'h01;
      cur_b <= tx[7:0];
      if (tx[7:0] > (cur_max >> 4))
        ol_m[1] = 0;
      wait_clk(4);
      chk("status", status, exp_stat());
    end
    @(posedge clk);
    cur_b <= 8'h00;
    $display("test short guard done");
    // three full frames, then one bit short
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      upper <= 12'($random(seed));
      {pw, stall, stst} <= 3'($random(seed));
      tx = 20'($random(seed));
      i_master.xfer(tx, (f == 3) ? 19 : 20, rx);
      got = 1'h0;
      for (int t = 0; t < 12; t++) begin
        wait_clk(1);
        if (wr_valid === 1'h1) begin
          got = 1'h1;
          chk("frame in", wr_data, tx);
        end
      end
      chk("frame valid", got, f < 3);
      if (f < 3)
        chk("frame out", rx, {upper, exp_stat()});
      chk("sdo enable idle", sdo_oe, 0);
    end
    $display("test serial frames done");
    end_sim();
  end
endmodule : driver_diag_status_spi_test
`default_nettype wire
